// File: shared/pcof_pkg.sv
// package: register map, reset values and limits of the position change on fly block
package pcof_pkg;
    // =========================================================
    // register byte offsets
    localparam logic [7:0] PCOF_ADDR_CTRL = 8'h00;
    localparam logic [7:0] PCOF_ADDR_DISP = 8'h04;
    localparam logic [7:0] PCOF_ADDR_MAXSPD = 8'h08;
    localparam logic [7:0] PCOF_ADDR_RAMP = 8'h0c;
    localparam logic [7:0] PCOF_ADDR_STATUS = 8'h10;
    localparam logic [7:0] PCOF_ADDR_TARGET = 8'h14;
    localparam logic [7:0] PCOF_ADDR_PROFILE = 8'h18;
    // =========================================================
    // control register field positions
    localparam int PCOF_CTRL_ENABLE_BIT = 0;
    localparam int PCOF_CTRL_LOCK_BIT = 1;
    localparam int PCOF_CTRL_DIR_BIT = 2;
    // =========================================================
    // values after reset and setting limits
    localparam logic PCOF_ENABLE_RESET = 1'h0;
    localparam logic PCOF_LOCK_RESET = 1'h1;
    localparam logic PCOF_DIR_RESET = 1'h0;
    localparam logic [30:0] PCOF_DISP_RESET = 31'h0000_2710;
    localparam logic [30:0] PCOF_DISP_MAX = 31'h4000_0000;
    localparam logic [12:0] PCOF_MAXSPD_RESET = 13'h00c8;
    localparam logic [12:0] PCOF_MAXSPD_MAX = 13'h1770;
    localparam logic [9:0] PCOF_RAMP_RESET = 10'h064;
    localparam logic [9:0] PCOF_RAMP_MAX = 10'h3e8;
    // ramp time is given per this speed step in rpm
    localparam logic [15:0] PCOF_RAMP_SPEED_STEP = 16'h03e8;
    localparam logic [15:0] PCOF_MIN_SPEED = 16'h0001;
    // =========================================================
    // datapath widths
    localparam int PCOF_GEAR_W = 16;
    localparam int PCOF_DIV_W = 48;
    // =========================================================
    // sequencer states
    typedef enum logic [1:0] {
        pcof_idle,
        pcof_calc_pos,
        pcof_calc_ramp,
        pcof_move
    } pcof_state_type;
endpackage : pcof_pkg

// File: logic/pcof_edge_sync.sv
// two-stage synchroniser with rising edge detector for the trigger input
`timescale 1ns/10ps
module pcof_edge_sync
    import pcof_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw level and detected edge
    input wire logic level_in,
    output logic rise
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } pcof_sync_state_type;

    pcof_sync_state_type r;
    pcof_sync_state_type next_r;

    // =========================================================
    // next state
    always_comb
    begin
        next_r = r;
        next_r.meta = level_in;
        next_r.sync = r.meta;
        next_r.prev = r.sync;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else
            r <= next_r;
    end

    assign rise = r.sync & ~r.prev;
endmodule : pcof_edge_sync

// File: logic/pcof_divider.sv
// restoring sequential divider, one quotient bit per clock
`timescale 1ns/10ps
module pcof_divider
    import pcof_pkg::*;
#(
    parameter int DW = PCOF_DIV_W,
    parameter int VW = PCOF_GEAR_W
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request
    input wire logic start,
    input wire logic [DW-1:0] dividend,
    input wire logic [VW-1:0] divisor,
    // result
    output logic [DW-1:0] quotient,
    output logic done
);
    localparam int CW = $clog2(DW + 1);

    typedef struct packed {
        logic busy;
        logic done;
        logic [CW-1:0] count;
        logic [VW:0] rem;
        logic [DW-1:0] quo;
        logic [VW-1:0] dvs;
    } pcof_div_state_type;

    pcof_div_state_type r;
    pcof_div_state_type next_r;
    logic [VW:0] rem_sh;

    // =========================================================
    // one shift and subtract step per cycle
    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        rem_sh = {r.rem[VW-1:0], r.quo[DW-1]};
        if (start)
        begin
            next_r.busy = 1'b1;
            next_r.count = CW'(DW);
            next_r.rem = '0;
            next_r.quo = dividend;
            next_r.dvs = divisor;
        end
        else if (r.busy)
        begin
            if (rem_sh >= {1'b0, r.dvs})
            begin
                next_r.rem = rem_sh - {1'b0, r.dvs};
                next_r.quo = {r.quo[DW-2:0], 1'b1};
            end
            else
            begin
                next_r.rem = rem_sh;
                next_r.quo = {r.quo[DW-2:0], 1'b0};
            end
            next_r.count = r.count - CW'(1);
            if (r.count == CW'(1))
            begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else
            r <= next_r;
    end

    assign quotient = r.quo;
    assign done = r.done;
endmodule : pcof_divider

// File: logic/pcof_core.sv
// position change on fly sequencer with apb register file
`timescale 1ns/10ps
// Overview of operation
// R1: enable bit applied only at power-up load
// R2: trigger from ninth input, rising edge
// R3: homing enabled ignores the trigger
// R4: enabled function blocks other position references
// R5: on disable, lock select decides acceptance; a power-up load that clears enable accepts references whatever the lock select
// R6: displacement setting, clamped, applied immediately
// R7: zero displacement means function disabled
// R8: target equals displacement times gear ratio
// R9: max speed zero keeps prior speed, direction
// R10: nonzero max speed uses direction select
// R11: ramp setting, 0 to 1000 ms
// R12: ramp duration from speed step formula
// R13: lock select 0 accepts references after move
// R14: lock select 1 blocks references after move
// R15: unlock input releases the lock
// R16: flag possible reverse rotation, small displacement
// R17: synchronised edge, one move, edges ignored
module pcof_core
    import pcof_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // drive status and digital inputs
    input wire logic power_up_load,
    input wire logic fly_trigger_input,
    input wire logic fly_unlock_input,
    input wire logic homing_enable,
    input wire logic signed [15:0] motor_speed,
    input wire logic signed [31:0] pos_deviation,
    input wire logic [PCOF_GEAR_W-1:0] gear_num,
    input wire logic [PCOF_GEAR_W-1:0] gear_den,
    // other position reference sources in and out
    input wire logic ext_ref_valid,
    input wire logic [31:0] ext_ref_delta,
    output logic pos_ref_valid,
    output logic [31:0] pos_ref_delta,
    output logic ref_accept,
    // move command to the profile generator
    output logic move_start,
    output logic [31:0] move_target,
    output logic [15:0] move_speed_limit,
    output logic move_direction,
    output logic [15:0] move_ramp_ms,
    input wire logic move_done
);
    typedef struct packed {
        pcof_state_type state;
        logic cfg_enable;
        logic eff_enable;
        logic lock_sel;
        logic dir_sel;
        logic [30:0] disp;
        logic [12:0] max_speed;
        logic [9:0] ramp;
        logic released;
        logic [31:0] abs_speed;
        logic [31:0] target;
        logic [15:0] limit;
        logic dir;
        logic [15:0] ramp_ms;
        logic move_start;
        logic reverse_warn;
        logic [15:0] moves;
        logic div_start;
        logic rd_ready;
        logic [31:0] prdata;
        logic ref_valid;
        logic [31:0] ref_delta;
    } pcof_core_state_type;

    pcof_core_state_type r;
    pcof_core_state_type next_r;

    logic trig_rise;
    logic fly_on;
    logic accept;
    logic mapped;
    logic wr_en;
    logic [PCOF_DIV_W-1:0] div_dividend;
    logic [PCOF_GEAR_W-1:0] div_divisor;
    logic [PCOF_DIV_W-1:0] div_quotient;
    logic div_done;
    logic [31:0] speed_ext;
    logic [31:0] diff;
    logic [31:0] status_word;
    logic [31:0] speed_mag;

    // =========================================================
    // magnitude of a two's complement word
    function automatic logic [31:0] pcof_mag(input logic [31:0] v);
        pcof_mag = v[31] ? (32'h0 - v) : v;
    endfunction : pcof_mag

    // =========================================================
    // trigger synchroniser and shared divider
    pcof_edge_sync u_trig
    (
        .pclk(pclk),
        .presetn(presetn),
        .level_in(fly_trigger_input), // [R2]
        .rise(trig_rise)
    );

    pcof_divider #(
        .DW(PCOF_DIV_W),
        .VW(PCOF_GEAR_W)
    ) u_div
    (
        .pclk(pclk),
        .presetn(presetn),
        .start(r.div_start),
        .dividend(div_dividend),
        .divisor(div_divisor),
        .quotient(div_quotient),
        .done(div_done)
    );

    // =========================================================
    // derived terms
    assign fly_on = r.eff_enable && (r.disp != 31'h0); // [R7]
    assign accept = r.released && (r.state == pcof_idle); // [R4]
    assign speed_ext = {{16{motor_speed[15]}}, motor_speed};
    assign speed_mag = pcof_mag(speed_ext);
    assign diff = pcof_mag({19'h0, r.max_speed} - r.abs_speed);
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= PCOF_ADDR_PROFILE);
    assign wr_en = psel && penable && pwrite;
    assign status_word = {r.moves, 10'h0, r.dir, r.reverse_warn, (r.state != pcof_idle),
                          r.released, fly_on, r.eff_enable};

    always_comb
    begin
        if (r.state == pcof_calc_pos)
        begin
            div_dividend = PCOF_DIV_W'(r.disp) * PCOF_DIV_W'(gear_num); // [R8]
            div_divisor = gear_den;
        end
        else
        begin
            div_dividend = PCOF_DIV_W'(diff) * PCOF_DIV_W'(r.ramp); // [R12]
            div_divisor = PCOF_RAMP_SPEED_STEP;
        end
    end

    // =========================================================
    // next state
    always_comb
    begin
        next_r = r;
        next_r.move_start = 1'b0;
        next_r.div_start = 1'b0;

        // register writes
        if (wr_en && mapped)
        begin
            unique case (paddr)
                PCOF_ADDR_CTRL:
                begin
                    next_r.cfg_enable = pwdata[PCOF_CTRL_ENABLE_BIT];
                    next_r.lock_sel = pwdata[PCOF_CTRL_LOCK_BIT];
                    next_r.dir_sel = pwdata[PCOF_CTRL_DIR_BIT];
                end
                PCOF_ADDR_DISP:
                    next_r.disp = (pwdata > 32'(PCOF_DISP_MAX)) ? PCOF_DISP_MAX : pwdata[30:0]; // [R6]
                PCOF_ADDR_MAXSPD:
                    next_r.max_speed = (pwdata > 32'(PCOF_MAXSPD_MAX)) ? PCOF_MAXSPD_MAX : pwdata[12:0];
                PCOF_ADDR_RAMP:
                    next_r.ramp = (pwdata > 32'(PCOF_RAMP_MAX)) ? PCOF_RAMP_MAX : pwdata[9:0]; // [R11]
                default:
                    next_r.ramp = r.ramp;
            endcase
        end

        // register reads, one wait state
        next_r.rd_ready = psel && penable && !pwrite && !r.rd_ready;
        if (psel && penable && !pwrite && !r.rd_ready)
        begin
            next_r.prdata = 32'h0;
            if (mapped)
            begin
                unique case (paddr)
                    PCOF_ADDR_CTRL:
                        next_r.prdata = {29'h0, r.dir_sel, r.lock_sel, r.cfg_enable};
                    PCOF_ADDR_DISP:
                        next_r.prdata = {1'h0, r.disp};
                    PCOF_ADDR_MAXSPD:
                        next_r.prdata = {19'h0, r.max_speed};
                    PCOF_ADDR_RAMP:
                        next_r.prdata = {22'h0, r.ramp};
                    PCOF_ADDR_STATUS:
                        next_r.prdata = status_word;
                    PCOF_ADDR_TARGET:
                        next_r.prdata = r.target;
                    default:
                        next_r.prdata = {r.ramp_ms, r.limit};
                endcase
            end
        end

        // move sequencer
        unique case (r.state)
            pcof_idle:
            begin
                if (fly_on && trig_rise && !homing_enable) // [R3] [R17]
                begin
                    next_r.released = 1'b0; // [R4]
                    next_r.abs_speed = speed_mag;
                    if (r.max_speed == 13'h0)
                    begin
                        // hold the speed and direction seen before the trigger
                        next_r.limit = (speed_mag == 32'h0) ? PCOF_MIN_SPEED : speed_mag[15:0]; // [R9]
                        next_r.dir = motor_speed[15]; // [R9]
                    end
                    else
                    begin
                        next_r.limit = {3'h0, r.max_speed}; // [R10]
                        next_r.dir = r.dir_sel; // [R10]
                    end
                    next_r.div_start = 1'b1;
                    next_r.state = pcof_calc_pos;
                end
                else
                begin
                    if (!r.released && fly_unlock_input) // [R15]
                        next_r.released = 1'b1;
                    if (!fly_on && !r.lock_sel) // [R5]
                        next_r.released = 1'b1;
                end
            end
            pcof_calc_pos:
            begin
                if (div_done)
                begin
                    next_r.target = div_quotient[31:0]; // [R8]
                    // large deviation against a small move may turn the motor back
                    next_r.reverse_warn = pcof_mag(pos_deviation) >= div_quotient[31:0]; // [R16]
                    next_r.div_start = 1'b1;
                    next_r.state = pcof_calc_ramp;
                end
            end
            pcof_calc_ramp:
            begin
                if (div_done)
                begin
                    next_r.ramp_ms = div_quotient[15:0]; // [R12]
                    next_r.move_start = 1'b1;
                    next_r.state = pcof_move;
                end
            end
            pcof_move:
            begin
                if (move_done) // [R17]
                begin
                    next_r.released = !r.lock_sel; // [R13] [R14]
                    next_r.moves = r.moves + 16'h0001;
                    next_r.state = pcof_idle;
                end
            end
        endcase

        // enable change only on a power-up load; last, so it outranks the idle release paths
        if (power_up_load)
        begin
            next_r.eff_enable = r.cfg_enable; // [R1]
            next_r.released = !r.cfg_enable; // [R4]
        end

        // gate the other reference sources
        next_r.ref_valid = ext_ref_valid && accept; // [R4] [R13] [R14]
        next_r.ref_delta = ext_ref_delta;
    end

    // =========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.state <= pcof_idle;
            r.cfg_enable <= PCOF_ENABLE_RESET;
            r.lock_sel <= PCOF_LOCK_RESET;
            r.dir_sel <= PCOF_DIR_RESET;
            r.disp <= PCOF_DISP_RESET;
            r.max_speed <= PCOF_MAXSPD_RESET;
            r.ramp <= PCOF_RAMP_RESET;
            r.released <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    // =========================================================
    // outputs
    assign prdata = r.prdata;
    assign pready = penable && (pwrite || r.rd_ready);
    assign pslverr = penable && (pwrite || r.rd_ready) && !mapped;
    assign pos_ref_valid = r.ref_valid;
    assign pos_ref_delta = r.ref_delta;
    assign ref_accept = accept;
    assign move_start = r.move_start;
    assign move_target = r.target;
    assign move_speed_limit = r.limit;
    assign move_direction = r.dir;
    assign move_ramp_ms = r.ramp_ms;
endmodule : pcof_core

// File: test/pcof_partner.sv
// partner model: other reference source and profile generator answer
`timescale 1ns/10ps
module pcof_partner
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // profile generator handshake
    input wire logic move_start,
    input wire logic [7:0] done_wait,
    output logic move_done,
    // other position reference source
    output logic ext_ref_valid,
    output logic [31:0] ext_ref_delta
);
    logic [7:0] wait_cnt;
    // =========================================================
    // answers a move done_wait + 1 cycles after move_start rises, streams references
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_cnt <= 8'h00;
            move_done <= 1'b0;
            ext_ref_valid <= 1'b0;
            ext_ref_delta <= 32'h0000_0000;
        end
        else
        begin
            move_done <= (wait_cnt == 8'h01);
            if (move_start)
                wait_cnt <= done_wait;
            else if (wait_cnt != 8'h00)
                wait_cnt <= wait_cnt - 8'h01;
            ext_ref_valid <= ~ext_ref_valid;
            ext_ref_delta <= ext_ref_delta + 32'h1357_9bdf;
        end
    end
endmodule : pcof_partner

// File: test/pcof_chk.sv
// checker: timing relations at the ports of the fly position block
`timescale 1ns/10ps
module pcof_chk
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // references and move command
    input wire logic ext_ref_valid,
    input wire logic [31:0] ext_ref_delta,
    input wire logic pos_ref_valid,
    input wire logic [31:0] pos_ref_delta,
    input wire logic ref_accept,
    input wire logic move_start,
    input wire logic [15:0] move_speed_limit,
    input wire logic [15:0] move_ramp_ms
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // =========================================================
    // properties
    property p_start_pulse;
        move_start |=> !move_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("move start longer than one cycle");
    property p_busy_blocks;
        move_start |-> !ref_accept;
    endproperty
    a_busy_blocks: assert property (p_busy_blocks) else $error("references accepted during move");
    property p_gate;
        pos_ref_valid |-> $past(ref_accept) && $past(ext_ref_valid);
    endproperty
    a_gate: assert property (p_gate) else $error("reference passed while blocked");
    property p_pass;
        ref_accept && ext_ref_valid |=> pos_ref_valid && pos_ref_delta == $past(ext_ref_delta);
    endproperty
    a_pass: assert property (p_pass) else $error("accepted reference not passed");
    property p_min_speed;
        move_start |-> move_speed_limit >= 16'h0001;
    endproperty
    a_min_speed: assert property (p_min_speed) else $error("speed limit below one");
    property p_hold;
        !move_start |-> $stable(move_ramp_ms) && ($stable(move_speed_limit) || !ref_accept);
    endproperty
    a_hold: assert property (p_hold) else $error("move profile changed outside start");
    property p_write;
        psel && penable && pwrite |-> pready;
    endproperty
    a_write: assert property (p_write) else $error("write not taken at once");
    property p_read_wait;
        psel && penable && !pwrite && !$past(penable) |-> !pready ##1 pready;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    property p_unmapped;
        psel && penable && pready && paddr > 8'h18 |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");
endmodule : pcof_chk
bind pcof_core pcof_chk u_chk (.*);

// File: test/test_position_change_on_fly.sv
// testbench: register access, fly moves and reference locking
`timescale 1ns/10ps
module test_position_change_on_fly
    import pcof_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, got;
    logic [7:0] paddr, done_wait;
    logic [31:0] pwdata, prdata, rdata, ext_ref_delta, pos_ref_delta, move_target;
    logic power_up_load, fly_trigger_input, fly_unlock_input, homing_enable;
    logic signed [15:0] motor_speed;
    logic signed [31:0] pos_deviation;
    logic [PCOF_GEAR_W-1:0] gear_num, gear_den;
    logic ext_ref_valid, pos_ref_valid, ref_accept, move_start, move_direction, move_done;
    logic [15:0] move_speed_limit, move_ramp_ms;
    logic [7:0] ca [3] = '{PCOF_ADDR_DISP, PCOF_ADDR_MAXSPD, PCOF_ADDR_RAMP};
    logic [31:0] cm [3] = '{{1'b0, PCOF_DISP_MAX}, {19'h0, PCOF_MAXSPD_MAX}, {22'h0, PCOF_RAMP_MAX}};
    int mismatches, n_compared, n_starts;
    pcof_core dut (.*);
    pcof_partner u_partner (.*);
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(negedge pclk)
        if (move_start === 1'b1)
            n_starts++;
    // =========================================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic trig();
        @(posedge pclk);
        fly_trigger_input <= 1'b1;
        repeat (4) @(posedge pclk);
        fly_trigger_input <= 1'b0;
    endtask : trig
    task automatic pup();
        @(posedge pclk);
        power_up_load <= 1'b1;
        @(posedge pclk);
        power_up_load <= 1'b0;
        repeat (2) @(negedge pclk);
    endtask : pup
    task automatic wait_start();
        got = 1'b0;
        for (int n = 0; n < 300 && !got; n++)
        begin
            @(negedge pclk);
            got = (move_start === 1'b1);
        end
    endtask : wait_start
    task automatic move_check(input logic [31:0] tg, input logic [15:0] sp, input logic dr, input logic [15:0] rp);
        wait_start();
        check({31'h0, got}, 32'h1);
        check(move_target, tg);
        check({16'h0, move_speed_limit}, {16'h0, sp});
        check({31'h0, move_direction}, {31'h0, dr});
        check({16'h0, move_ramp_ms}, {16'h0, rp});
    endtask : move_check
    task automatic stop_test();
        $display("counts: %0d compared, %0d mismatches", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        stop_test();
    end
    // =========================================================
    // tests
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        power_up_load = 1'b0;
        fly_trigger_input = 1'b0;
        fly_unlock_input = 1'b0;
        homing_enable = 1'b0;
        motor_speed = 16'sd0;
        pos_deviation = 32'sd0;
        gear_num = 16'd1;
        gear_den = 16'd1;
        done_wait = 8'd1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, PCOF_ADDR_CTRL, 32'h0);
        check(rdata, {29'h0, PCOF_DIR_RESET, PCOF_LOCK_RESET, PCOF_ENABLE_RESET});
        xfer(1'b0, PCOF_ADDR_DISP, 32'h0);
        check(rdata, {1'b0, PCOF_DISP_RESET});
        xfer(1'b0, PCOF_ADDR_MAXSPD, 32'h0);
        check(rdata, {19'h0, PCOF_MAXSPD_RESET});
        xfer(1'b0, PCOF_ADDR_RAMP, 32'h0);
        check(rdata, {22'h0, PCOF_RAMP_RESET});
        xfer(1'b1, PCOF_ADDR_STATUS, 32'hffff_ffff);
        xfer(1'b0, PCOF_ADDR_STATUS, 32'h0);
        check(rdata, 32'h4);
        xfer(1'b0, 8'h1c, 32'h0);
        check({31'h0, rerr}, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b1, ca[i], 32'hffff_ffff);
            xfer(1'b0, ca[i], 32'h0);
            check(rdata, cm[i]);
        end
        $display("test reset and limits done");
        xfer(1'b1, PCOF_ADDR_CTRL, 32'h1);
        xfer(1'b0, PCOF_ADDR_STATUS, 32'h0);
        check(rdata & 32'h1, 32'h0);
        pup();
        check({31'h0, ref_accept}, 32'h0);
        xfer(1'b0, PCOF_ADDR_STATUS, 32'h0);
        check(rdata & 32'h1, 32'h1);
        for (int i = 0; i < 2; i++)
        begin
            xfer(1'b1, PCOF_ADDR_DISP, (i == 0) ? 32'd3000 : 32'd0);
            homing_enable <= (i == 0);
            trig();
            wait_start();
            check({31'h0, got}, 32'h0);
        end
        xfer(1'b0, PCOF_ADDR_STATUS, 32'h0);
        check(rdata & 32'h2, 32'h0);
        $display("test enable and shielding done");
        xfer(1'b1, PCOF_ADDR_DISP, 32'd3000);
        xfer(1'b1, PCOF_ADDR_MAXSPD, 32'd0);
        xfer(1'b1, PCOF_ADDR_RAMP, 32'd500);
        gear_num <= 16'd4;
        gear_den <= 16'd3;
        motor_speed <= -16'sd300;
        pos_deviation <= 32'sd100;
        trig();
        trig();
        move_check(32'd3000 * 32'd4 / 32'd3, 16'd300, 1'b1, 16'(32'd300 * 32'd500 / 32'd1000));
        repeat (8) @(negedge pclk);
        check({31'h0, ref_accept}, 32'h1);
        check(n_starts, 32'd1);
        xfer(1'b0, PCOF_ADDR_STATUS, 32'h0);
        check(rdata & 32'h10, 32'h0);
        $display("test unlocked move done");
        xfer(1'b1, PCOF_ADDR_CTRL, 32'h3);
        xfer(1'b1, PCOF_ADDR_DISP, 32'd1000);
        xfer(1'b1, PCOF_ADDR_MAXSPD, 32'd1000);
        gear_num <= 16'd2;
        gear_den <= 16'd1;
        motor_speed <= 16'sd200;
        pos_deviation <= -32'sd5000;
        done_wait <= 8'd40;
        trig();
        move_check(32'd1000 * 32'd2, 16'd1000, 1'b0, 16'(32'd800 * 32'd500 / 32'd1000));
        repeat (60) @(negedge pclk);
        check({31'h0, ref_accept}, 32'h0);
        xfer(1'b0, PCOF_ADDR_STATUS, 32'h0);
        check(rdata & 32'hffff_0010, 32'h0002_0010);
        fly_unlock_input <= 1'b1;
        repeat (3) @(posedge pclk);
        fly_unlock_input <= 1'b0;
        @(negedge pclk);
        check({31'h0, ref_accept}, 32'h1);
        $display("test locked move done");
        pup();
        check({31'h0, ref_accept}, 32'h0);
        xfer(1'b1, PCOF_ADDR_CTRL, 32'h2);
        pup();
        check({31'h0, ref_accept}, 32'h1);
        $display("test disable done");
        stop_test();
    end
endmodule : test_position_change_on_fly
